/* File: bench/dmcr_bank_bench.sv */
`timescale 1ns/1ps
module dmcr_bank_bench;
  logic mclk = 1'b0;
  logic rst, ctl_select_n, ctl_clk, ctl_data_in, ctl_data_out;
  logic ctl_data_out_oe, mute_pin, lrck, one_bit_mode;
  logic zero_left_in, zero_right_in;
  logic [7:0] left_atten_applied, right_atten_applied;
  logic [2:0] audio_format_sel;
  logic [1:0] deemph_rate_sel, fir_filter_sel, atten_step_rate;
  logic [1:0] modulator_rate_sel;
  logic left_silenced, right_silenced, soft_mute, deemph_enable;
  logic phase_invert, dac_output_disable, clock_out_divide;
  logic clock_out_disable, filter_rolloff_sel, zero_detect_mute_en;
  logic system_reset_ctl, register_defaults_ctl, filter_bypass;
  logic monaural_sel, monaural_sel_channel_sel;
  logic [2:0] lr_cnt;
  int n_fail = 0;
  int comparisons = 0;

  dmcr_bank i_dut (.mclk, .rst, .ctl_select_n, .ctl_clk, .ctl_data_in,
    .ctl_data_out, .ctl_data_out_oe, .mute_pin, .lrck, .one_bit_mode,
    .zero_left_in, .zero_right_in, .left_atten_applied,
    .right_atten_applied, .left_silenced, .right_silenced, .soft_mute,
    .audio_format_sel, .deemph_enable, .deemph_rate_sel, .fir_filter_sel,
    .phase_invert, .atten_step_rate, .dac_output_disable, .clock_out_divide,
    .clock_out_disable, .filter_rolloff_sel, .zero_detect_mute_en,
    .system_reset_ctl, .register_defaults_ctl, .filter_bypass,
    .monaural_sel, .monaural_sel_channel_sel, .modulator_rate_sel);
  dmcr_host i_host (.mclk, .ctl_select_n, .ctl_clk, .ctl_data_in,
    .ctl_data_out, .ctl_data_out_oe);

  always #2 mclk = ~mclk;

  // Frame clock, 16 system clocks a frame
  always @(negedge mclk) begin
    lr_cnt <= lr_cnt + 3'h1;
    if (lr_cnt == 3'h7)
      lrck <= ~lrck;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] r;
    i_host.xfer({1'b0, idx, d}, r);
  endtask
  task rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    i_host.xfer({1'b1, idx, 8'h00}, r);
    check(r, exp, "read");
  endtask
  task frames(input int n);
    repeat (n * 16) @(negedge mclk);
  endtask

  task final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task t_reset;
    check(left_atten_applied, 8'hff, "left level");
    check(right_atten_applied, 8'hff, "right level");
    check({audio_format_sel, deemph_rate_sel, deemph_enable, soft_mute,
      1'b0}, 8'h00, "ctrl pins");
    check({phase_invert, atten_step_rate, 5'h0}, 8'h00, "rev rate");
    for (int i = 0; i < 7; i++)
      rd_chk(7'h10 + i[6:0], i < 2 ? 8'hff : 8'h00);
  endtask

  task t_regs;
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h74 : 8'h8b;
      wr(7'h13, v);
      check({phase_invert, atten_step_rate, dac_output_disable,
        clock_out_divide, clock_out_disable, filter_rolloff_sel,
        zero_detect_mute_en}, v, "reg19 pins");
      rd_chk(7'h13, v);
    end
    wr(7'h13, 8'h00);
    wr(7'h14, 8'hff);
    rd_chk(7'h14, 8'h7f);
    check({1'b0, system_reset_ctl, register_defaults_ctl, filter_bypass,
      monaural_sel, monaural_sel_channel_sel, modulator_rate_sel}, 8'h7f, "reg20");
    wr(7'h14, 8'h00);
    zero_left_in = 1'b1;
    wr(7'h15, 8'hfe);
    rd_chk(7'h15, 8'h01);
    zero_left_in = 1'b0;
    zero_right_in = 1'b1;
    rd_chk(7'h15, 8'h02);
    zero_right_in = 1'b0;
  endtask

  task t_format;
    logic [2:0] e;
    for (int f = 0; f < 8; f++) begin
      e = f < 6 ? f[2:0] : 3'h5;
      wr(7'h12, {1'b0, f[2:0], 4'h0});
      check({5'h0, audio_format_sel}, {5'h0, e}, "format");
      rd_chk(7'h12, {1'b0, e, 4'h0});
    end
  endtask

  task t_deemph;
    for (int m = 0; m < 2; m++) begin
      one_bit_mode = m[0];
      repeat (8) @(negedge mclk);
      for (int r = 0; r < 4; r++) begin
        wr(7'h12, {4'h0, r[1:0], 2'b10});
        check({3'h0, deemph_enable, deemph_rate_sel, fir_filter_sel},
          {3'h1, m[0] ? 2'h0 : r[1:0], m[0] ? r[1:0] : 2'h0},
          "deemph");
      end
    end
    one_bit_mode = 1'b0;
    wr(7'h12, 8'h00);
  endtask

  task t_atten;
    wr(7'h10, 8'hfc);
    wr(7'h11, 8'hfe);
    frames(4);
    check(left_atten_applied, 8'hff, "frozen");
    wr(7'h12, 8'h80);
    frames(6);
    check(left_atten_applied, 8'hfc, "left load");
    check(right_atten_applied, 8'hfe, "right load");
    wr(7'h13, 8'h60);
    wr(7'h10, 8'hfe);
    frames(4);
    check({7'h0, left_atten_applied == 8'hfe}, 8'h00, "slow step");
    frames(16);
    check(left_atten_applied, 8'hfe, "slow done");
    wr(7'h13, 8'h00);
  endtask

  task t_mute;
    mute_pin = 1'b1;
    repeat (8) @(negedge mclk);
    check({7'h0, soft_mute}, 8'h01, "mute pin");
    frames(262);
    check(left_atten_applied, 8'h00, "muted left");
    check(right_atten_applied, 8'h00, "muted right");
    check({6'h0, left_silenced, right_silenced}, 8'h03, "silenced");
    mute_pin = 1'b0;
    repeat (8) @(negedge mclk);
    check({7'h0, soft_mute}, 8'h00, "mute off");
    wr(7'h12, 8'h81);
    check({7'h0, soft_mute}, 8'h01, "mute bit");
    wr(7'h12, 8'h80);
    frames(30);
    check({6'h0, left_silenced, right_silenced}, 8'h00, "audible");
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    final_report;
  end

  initial begin
    rst = 1'b1;
    mute_pin = 1'b0;
    lrck = 1'b0;
    lr_cnt = 3'h0;
    one_bit_mode = 1'b0;
    zero_left_in = 1'b0;
    zero_right_in = 1'b0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    t_reset;
    t_regs;
    t_format;
    t_deemph;
    t_atten;
    t_mute;
    final_report;
  end
endmodule

/* File: bench/dmcr_bank_sva.sv */
`timescale 1ns/1ps
module dmcr_bank_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched pins
  input wire logic ctl_select_n,
  input wire logic ctl_data_out_oe,
  input wire logic mute_pin,
  input wire logic lrck,
  input wire logic one_bit_mode,
  input wire logic [7:0] left_atten_applied,
  input wire logic left_silenced,
  input wire logic soft_mute,
  input wire logic [2:0] audio_format_sel,
  input wire logic [1:0] deemph_rate_sel,
  input wire logic [1:0] fir_filter_sel
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Cycles since the last frame clock rise, saturating
  logic [3:0] since_rise_reg;
  logic [3:0] since_rise_next;
  logic lrck_reg;

  always_comb begin
    if (lrck && !lrck_reg)
      since_rise_next = 4'h0;
    else if (since_rise_reg == 4'hf)
      since_rise_next = since_rise_reg;
    else
      since_rise_next = since_rise_reg + 4'h1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      since_rise_reg <= 4'hf;
      lrck_reg <= 1'b0;
    end else begin
      since_rise_reg <= since_rise_next;
      lrck_reg <= lrck;
    end
  end

  sequence pin_held;
    mute_pin[*8];
  endsequence
  sequence applied_moved;
    left_atten_applied != $past(left_atten_applied);
  endsequence

  silence_flag_a: assert property ($stable(left_atten_applied) |->
    left_silenced == (left_atten_applied <= 8'h0e))
    else $error("silenced flag does not match level");
  single_step_a: assert property (applied_moved |->
    (left_atten_applied == $past(left_atten_applied) + 8'h01 ||
     left_atten_applied == $past(left_atten_applied) - 8'h01))
    else $error("level moved by more than one code");
  frame_step_a: assert property (applied_moved |-> since_rise_reg <= 4'ha)
    else $error("level moved away from a frame tick");
  mute_pin_a: assert property (pin_held |-> soft_mute)
    else $error("mute pin did not engage soft mute");
  mute_walk_a: assert property (soft_mute && $past(soft_mute) |->
    left_atten_applied <= $past(left_atten_applied))
    else $error("level rose during soft mute");
  fmt_legal_a: assert property (!(audio_format_sel inside {3'h6, 3'h7}))
    else $error("reserved format reached the output");
  fir_idle_a: assert property ((!one_bit_mode)[*8] |-> fir_filter_sel == 2'h0)
    else $error("filter select active outside one-bit mode");
  rate_idle_a: assert property (one_bit_mode[*8] |-> deemph_rate_sel == 2'h0)
    else $error("rate select active in one-bit mode");
  oe_idle_a: assert property (ctl_select_n[*8] |-> !ctl_data_out_oe)
    else $error("read data driven outside a frame");
endmodule

bind dmcr_bank dmcr_bank_chk i_chk (.mclk(mclk), .rst(rst),
  .ctl_select_n(ctl_select_n), .ctl_data_out_oe(ctl_data_out_oe),
  .mute_pin(mute_pin), .lrck(lrck), .one_bit_mode(one_bit_mode),
  .left_atten_applied(left_atten_applied), .left_silenced(left_silenced),
  .soft_mute(soft_mute), .audio_format_sel(audio_format_sel),
  .deemph_rate_sel(deemph_rate_sel), .fir_filter_sel(fir_filter_sel));

/* File: bench/dmcr_host.sv */
`timescale 1ns/1ps
module dmcr_host (
  // Clock
  input wire logic mclk,
  // Serial control port
  output logic ctl_select_n,
  output logic ctl_clk,
  output logic ctl_data_in,
  input wire logic ctl_data_out,
  input wire logic ctl_data_out_oe
);
  initial begin
    ctl_select_n = 1'b1;
    ctl_clk = 1'b0;
    ctl_data_in = 1'b0;
  end

  task automatic half;
    repeat (4) @(negedge mclk);
  endtask

  // One frame, MSB first; read bits taken late in the high phase
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    ctl_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ctl_data_in = w[i];
      half;
      ctl_clk = 1'b1;
      half;
      if (i < 8)
        r[i] = ctl_data_out_oe ? ctl_data_out : 1'bx;
      ctl_clk = 1'b0;
    end
    half;
    ctl_select_n = 1'b1;
    // Released line shows the inverse of the last bit
    ctl_data_in = ~w[0];
    repeat (12) @(negedge mclk);
  endtask
endmodule

/* File: logic/dmcr_bank.sv */
`timescale 1ns/1ps
// What this block does
// - Word bit 15 low writes the data byte, high reads the register back.
// - Bits 14..8 carry the register index 16..21, bits 7..0 the data.
// - Each channel has an 8-bit level register resetting to all ones.
// - Codes 15..255 give half a dB times code minus 255 of attenuation.
// - Codes 0..14 silence the channel completely.
// - Levels are written separately; one shared load enable applies both.
// - Load enable low, its reset value, keeps the old applied levels.
// - Three-bit format field, reset 000; codes 110 and 111 are reserved.
// - Two-bit rate: 00 off, 01 48k, 10 44.1k, 11 32k.
// - De-emphasis enable, reset low, acts on both channels at the rate.
// - In one-bit stream mode the rate field selects the FIR filter.
// - The soft-mute bit, reset low, mutes both channels together.
// - A dedicated mute pin also triggers soft mute.
// - Soft mute steps the attenuator one step per interval to silence.
// - Phase invert bit, reset low, inverts both channel outputs.
// - Register 20 bit 7 and register 21 bits 7..2 are reserved.
// - Step rate 00 every frame, 01 second, 10 fourth, 11 eighth.
module dmcr_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial control port
  input wire logic ctl_select_n,
  input wire logic ctl_clk,
  input wire logic ctl_data_in,
  output logic ctl_data_out,
  output logic ctl_data_out_oe,
  // Device pins
  input wire logic mute_pin,
  input wire logic lrck,
  input wire logic one_bit_mode,
  // Zero detectors of the datapath
  input wire logic zero_left_in,
  input wire logic zero_right_in,
  // Attenuator
  output logic [7:0] left_atten_applied,
  output logic [7:0] right_atten_applied,
  output logic left_silenced,
  output logic right_silenced,
  output logic soft_mute,
  // Format and de-emphasis
  output logic [2:0] audio_format_sel,
  output logic deemph_enable,
  output logic [1:0] deemph_rate_sel,
  output logic [1:0] fir_filter_sel,
  // Output, clock and filter control
  output logic phase_invert,
  output logic [1:0] atten_step_rate,
  output logic dac_output_disable,
  output logic clock_out_divide,
  output logic clock_out_disable,
  output logic filter_rolloff_sel,
  output logic zero_detect_mute_en,
  // Reset, bypass and channel control
  output logic system_reset_ctl,
  output logic register_defaults_ctl,
  output logic filter_bypass,
  output logic monaural_sel,
  output logic monaural_sel_channel_sel,
  output logic [1:0] modulator_rate_sel
);
  typedef struct packed {
    // Serial port state and shifters
    dmcr_pkg::dmcr_port_t port;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic rd_mode;
    logic [6:0] index;
    logic [7:0] rd_shift;
    logic mdo;
    logic mdo_oe;
    // Edge history of the synced pins
    logic cs_prev;
    logic mc_prev;
    logic lrck_prev;
    logic frame_tick;
    // Register file
    logic [7:0] left_lvl;
    logic [7:0] right_lvl;
    logic [7:0] ctrl;
    logic [7:0] outclk;
    logic [7:0] sys;
    logic [1:0] zero_flags;
    // Registered controls for the attenuator and the converter
    logic [7:0] load_l;
    logic [7:0] load_r;
    logic mute_out;
    logic [1:0] rate_out;
    logic [1:0] fir_out;
  } dmcr_bank_t;

  dmcr_bank_t s_reg;
  dmcr_bank_t s_next;

  // Raw and synced pin levels
  logic [dmcr_pkg::SYNC_W-1:0] pins_raw;
  logic [dmcr_pkg::SYNC_W-1:0] pins;
  logic cs_n_s;
  logic mc_s;
  logic mdi_s;
  logic mute_s;
  logic lrck_s;
  logic one_bit_s;
  // Edges of the synced serial clock, late but free of glitches
  logic mc_rise;
  logic mc_fall;
  // Shift path and read-back data
  logic [15:0] shifted;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  // Carrier to the attenuator stepping module
  dmcr_ramp_if rif ();

  assign pins_raw = {one_bit_mode, lrck, mute_pin, ctl_data_in, ctl_clk,
                     ctl_select_n};

  // Every pin is asynchronous and passes the three-stage filter
  dmcr_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .raw(pins_raw),
    .stable(pins)
  );

  // Per-channel stepping toward the loaded level or toward silence
  dmcr_ramp u_ramp (
    .mclk(mclk),
    .rst(rst),
    .rif(rif)
  );

  // Lane order follows pins_raw, bit 0 first
  assign cs_n_s = pins[0];
  assign mc_s = pins[1];
  assign mdi_s = pins[2];
  assign mute_s = pins[3];
  assign lrck_s = pins[4];
  assign one_bit_s = pins[5];

  assign mc_rise = mc_s & ~s_reg.mc_prev;
  assign mc_fall = ~mc_s & s_reg.mc_prev;
  assign shifted = {s_reg.shift[14:0], mdi_s};
  assign wr_data = s_reg.shift[7:0];

  // Read-back mux on the index just received; unmapped indices read zero
  // The header is complete in shifted on the eighth rise, so the byte
  // is fetched in that cycle and the first read bit cannot lag it
  always_comb begin
    rd_data = 8'h00;
    case (shifted[6:0])
      dmcr_pkg::IDX_LEFT: begin
        rd_data = s_reg.left_lvl;
      end
      dmcr_pkg::IDX_RIGHT: begin
        rd_data = s_reg.right_lvl;
      end
      dmcr_pkg::IDX_CTRL: begin
        rd_data = s_reg.ctrl;
      end
      dmcr_pkg::IDX_OUTCLK: begin
        rd_data = s_reg.outclk;
      end
      dmcr_pkg::IDX_SYS: begin
        rd_data = s_reg.sys & dmcr_pkg::SYS_MASK;
      end
      dmcr_pkg::IDX_ZERO: begin
        rd_data = {6'h00, s_reg.zero_flags};
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // Next state of the serial port, the register file and the outputs
  always_comb begin
    s_next = s_reg;
    // Edge history and a tick per rising frame clock edge
    s_next.cs_prev = cs_n_s;
    s_next.mc_prev = mc_s;
    s_next.lrck_prev = lrck_s;
    s_next.frame_tick = lrck_s & ~s_reg.lrck_prev;
    // Zero flags are sampled every clock and are never written
    s_next.zero_flags = {zero_right_in, zero_left_in};
    case (s_reg.port)
      dmcr_pkg::PORT_IDLE: begin
        s_next.mdo_oe = 1'b0;
        // A falling select clears the count; the shifter needs no clear
        if (!cs_n_s) begin
          s_next.port = dmcr_pkg::PORT_HEAD;
          s_next.bit_cnt = 5'h00;
        end
      end
      dmcr_pkg::PORT_HEAD: begin
        if (cs_n_s) begin
          s_next.port = dmcr_pkg::PORT_IDLE;
        end else if (mc_rise) begin
          s_next.shift = shifted;
          s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
          if (s_reg.bit_cnt + 5'h01 == dmcr_pkg::HEAD_BITS) begin
            // Flag and index are the first eight bits
            s_next.port = dmcr_pkg::PORT_BODY;
            s_next.rd_mode = shifted[7];
            s_next.index = shifted[6:0];
            s_next.rd_shift = rd_data;
          end
        end
      end
      dmcr_pkg::PORT_BODY: begin
        if (cs_n_s) begin
          s_next.port = dmcr_pkg::PORT_IDLE;
          s_next.mdo_oe = 1'b0;
          // Only a complete write word is committed
          // Commit waits for the synced select rise, so a word cut short
          // by the host leaves every register untouched
          if (s_reg.bit_cnt == dmcr_pkg::WORD_BITS && !s_reg.rd_mode) begin
            case (s_reg.index)
              dmcr_pkg::IDX_LEFT: begin
                s_next.left_lvl = wr_data;
              end
              dmcr_pkg::IDX_RIGHT: begin
                s_next.right_lvl = wr_data;
              end
              dmcr_pkg::IDX_CTRL: begin
                if (wr_data[dmcr_pkg::FMT_MSB:dmcr_pkg::FMT_LSB]
                      != dmcr_pkg::FMT_RSV_A &&
                    wr_data[dmcr_pkg::FMT_MSB:dmcr_pkg::FMT_LSB]
                      != dmcr_pkg::FMT_RSV_B) begin
                  s_next.ctrl = wr_data;
                end
              end
              dmcr_pkg::IDX_OUTCLK: begin
                s_next.outclk = wr_data;
              end
              dmcr_pkg::IDX_SYS: begin
                s_next.sys = wr_data & dmcr_pkg::SYS_MASK;
              end
              default: begin
                s_next.sys = s_reg.sys;
              end
            endcase
          end
        end else begin
          // Read data leaves on falling edges, MSB first
          // The output enable stays up until select rises
          if (mc_fall && s_reg.rd_mode &&
              s_reg.bit_cnt < dmcr_pkg::WORD_BITS) begin
            s_next.mdo = s_reg.rd_shift[7];
            s_next.rd_shift = {s_reg.rd_shift[6:0], 1'b0};
            s_next.mdo_oe = 1'b1;
          end
          if (mc_rise && s_reg.bit_cnt < dmcr_pkg::WORD_BITS) begin
            s_next.shift = shifted;
            s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
          end
        end
      end
      default: begin
        s_next.port = dmcr_pkg::PORT_IDLE;
      end
    endcase
    // New levels reach the attenuator only while loading is enabled
    // Turning loading on also takes a level written while it was off
    if (s_next.ctrl[dmcr_pkg::LOAD_BIT]) begin
      s_next.load_l = s_next.left_lvl;
      s_next.load_r = s_next.right_lvl;
    end
    s_next.mute_out = s_next.ctrl[dmcr_pkg::MUTE_BIT] | mute_s;
    // Rate field drives de-emphasis or the FIR selector
    // The destination not in use is held at zero
    if (one_bit_s) begin
      s_next.rate_out = 2'h0;
      s_next.fir_out = s_next.ctrl[dmcr_pkg::DMF_MSB:dmcr_pkg::DMF_LSB];
    end else begin
      s_next.rate_out = s_next.ctrl[dmcr_pkg::DMF_MSB:dmcr_pkg::DMF_LSB];
      s_next.fir_out = 2'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Levels start at 0 dB and every control field starts cleared
      s_reg <= '0;
      s_reg.port <= dmcr_pkg::PORT_IDLE;
      s_reg.cs_prev <= 1'b1;
      s_reg.left_lvl <= dmcr_pkg::LEVEL_RESET;
      s_reg.right_lvl <= dmcr_pkg::LEVEL_RESET;
      s_reg.load_l <= dmcr_pkg::LEVEL_RESET;
      s_reg.load_r <= dmcr_pkg::LEVEL_RESET;
      s_reg.ctrl <= dmcr_pkg::CTRL_RESET;
      s_reg.outclk <= dmcr_pkg::OUTCLK_RESET;
      s_reg.sys <= dmcr_pkg::SYS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Attenuator controls leave registers, so a step sees settled values
  assign rif.frame_tick = s_reg.frame_tick;
  assign rif.step_rate = s_reg.outclk[dmcr_pkg::ATS_MSB:dmcr_pkg::ATS_LSB];
  assign rif.soft_mute = s_reg.mute_out;
  assign rif.target = {s_reg.load_r, s_reg.load_l};

  // Serial port
  assign ctl_data_out = s_reg.mdo;
  assign ctl_data_out_oe = s_reg.mdo_oe;

  // Attenuator
  assign left_atten_applied = rif.applied[0];
  assign right_atten_applied = rif.applied[1];
  assign left_silenced = rif.silenced[0];
  assign right_silenced = rif.silenced[1];
  assign soft_mute = s_reg.mute_out;

  // Format and de-emphasis
  assign audio_format_sel = s_reg.ctrl[dmcr_pkg::FMT_MSB:dmcr_pkg::FMT_LSB];
  assign deemph_enable = s_reg.ctrl[dmcr_pkg::DME_BIT];
  assign deemph_rate_sel = s_reg.rate_out;
  assign fir_filter_sel = s_reg.fir_out;

  // Output, clock and filter control
  assign phase_invert = s_reg.outclk[dmcr_pkg::REV_BIT];
  assign atten_step_rate = rif.step_rate;
  assign dac_output_disable = s_reg.outclk[dmcr_pkg::OPE_BIT];
  assign clock_out_divide = s_reg.outclk[dmcr_pkg::CLOCK_OUT_DIVIDE_BIT];
  assign clock_out_disable = s_reg.outclk[dmcr_pkg::CLOCK_OUT_DISABLE_BIT];
  assign filter_rolloff_sel = s_reg.outclk[dmcr_pkg::FLT_BIT];
  assign zero_detect_mute_en = s_reg.outclk[dmcr_pkg::ZERO_DETECT_MUTE_EN_BIT];

  // Reset, bypass and channel control: stored and shown only
  assign system_reset_ctl = s_reg.sys[dmcr_pkg::SYSTEM_RESET_CTL_BIT];
  assign register_defaults_ctl = s_reg.sys[dmcr_pkg::REGISTER_DEFAULTS_CTL_BIT];
  assign filter_bypass = s_reg.sys[dmcr_pkg::FILTER_BYPASS_BIT];
  assign monaural_sel = s_reg.sys[dmcr_pkg::MONAURAL_SEL_BIT];
  assign monaural_sel_channel_sel = s_reg.sys[dmcr_pkg::MONAURAL_SEL_CHANNEL_SEL_BIT];
  assign modulator_rate_sel = s_reg.sys[dmcr_pkg::OS_MSB:dmcr_pkg::OS_LSB];
endmodule

/* File: logic/dmcr_pkg.sv */
package dmcr_pkg;
  // Control word layout
  localparam int RW_BIT = 15;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 8;
  localparam logic [4:0] HEAD_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;

  // Register indices
  localparam logic [6:0] IDX_LEFT = 7'h10;
  localparam logic [6:0] IDX_RIGHT = 7'h11;
  localparam logic [6:0] IDX_CTRL = 7'h12;
  localparam logic [6:0] IDX_OUTCLK = 7'h13;
  localparam logic [6:0] IDX_SYS = 7'h14;
  localparam logic [6:0] IDX_ZERO = 7'h15;

  // Format, de-emphasis and mute control fields
  localparam int LOAD_BIT = 7;
  localparam int FMT_MSB = 6;
  localparam int FMT_LSB = 4;
  localparam int DMF_MSB = 3;
  localparam int DMF_LSB = 2;
  localparam int DME_BIT = 1;
  localparam int MUTE_BIT = 0;
  localparam logic [2:0] FMT_RSV_A = 3'h6;
  localparam logic [2:0] FMT_RSV_B = 3'h7;

  // Output, clock and filter control fields
  localparam int REV_BIT = 7;
  localparam int ATS_MSB = 6;
  localparam int ATS_LSB = 5;
  localparam int OPE_BIT = 4;
  localparam int CLOCK_OUT_DIVIDE_BIT = 3;
  localparam int CLOCK_OUT_DISABLE_BIT = 2;
  localparam int FLT_BIT = 1;
  localparam int ZERO_DETECT_MUTE_EN_BIT = 0;

  // Reset, bypass and channel fields
  localparam int SYSTEM_RESET_CTL_BIT = 6;
  localparam int REGISTER_DEFAULTS_CTL_BIT = 5;
  localparam int FILTER_BYPASS_BIT = 4;
  localparam int MONAURAL_SEL_BIT = 3;
  localparam int MONAURAL_SEL_CHANNEL_SEL_BIT = 2;
  localparam int OS_MSB = 1;
  localparam int OS_LSB = 0;
  localparam logic [7:0] SYS_MASK = 8'h7f;

  // Reset values
  localparam logic [7:0] LEVEL_RESET = 8'hff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OUTCLK_RESET = 8'h00;
  localparam logic [7:0] SYS_RESET = 8'h00;

  // Attenuator levels and stepping
  localparam logic [7:0] LEVEL_SILENT_MAX = 8'h0e;
  localparam logic [7:0] LEVEL_FLOOR = 8'h00;
  localparam logic [3:0][2:0] STEP_LIMIT = {3'h7, 3'h3, 3'h1, 3'h0};

  // Synchroniser lanes: cs_n, mc, mdi, mute pin, lrck, one-bit mode
  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_INIT = 6'h01;

  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_HEAD,
    PORT_BODY
  } dmcr_port_t;
endpackage

/* File: logic/dmcr_ramp.sv */
`timescale 1ns/1ps
module dmcr_ramp (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Attenuator control from the register bank
  dmcr_ramp_if.ramp rif
);
  typedef struct packed {
    logic [2:0] frame_cnt;
    logic [1:0][7:0] level;
    logic [1:0] silenced;
  } dmcr_ramp_t;

  dmcr_ramp_t s_reg;
  dmcr_ramp_t s_next;
  logic step;
  logic [7:0] goal;

  always_comb begin
    s_next = s_reg;
    step = 1'b0;
    goal = dmcr_pkg::LEVEL_FLOOR;
    // One step every 1, 2, 4 or 8 frames
    if (rif.frame_tick) begin
      if (s_reg.frame_cnt >= dmcr_pkg::STEP_LIMIT[rif.step_rate]) begin
        s_next.frame_cnt = 3'h0;
        step = 1'b1;
      end else begin
        s_next.frame_cnt = s_reg.frame_cnt + 3'h1;
      end
    end
    for (int ch = 0; ch < 2; ch++) begin
      // Mute walks down to the floor, otherwise toward the loaded level
      goal = rif.soft_mute ? dmcr_pkg::LEVEL_FLOOR : rif.target[ch];
      if (step && s_reg.level[ch] < goal) begin
        s_next.level[ch] = s_reg.level[ch] + 8'h01;
      end else if (step && s_reg.level[ch] > goal) begin
        s_next.level[ch] = s_reg.level[ch] - 8'h01;
      end
      // Codes up to 14 are full silence
      s_next.silenced[ch] = s_next.level[ch] <= dmcr_pkg::LEVEL_SILENT_MAX;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg.frame_cnt <= 3'h0;
      s_reg.level <= {2{dmcr_pkg::LEVEL_RESET}};
      s_reg.silenced <= 2'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rif.applied = s_reg.level;
  assign rif.silenced = s_reg.silenced;
endmodule

/* File: logic/dmcr_ramp_if.sv */
`timescale 1ns/1ps
interface dmcr_ramp_if;
  logic frame_tick;
  logic [1:0] step_rate;
  logic soft_mute;
  logic [1:0][7:0] target;
  logic [1:0][7:0] applied;
  logic [1:0] silenced;

  modport ctrl (
    output frame_tick, step_rate, soft_mute, target,
    input applied, silenced
  );
  modport ramp (
    input frame_tick, step_rate, soft_mute, target,
    output applied, silenced
  );
endinterface

/* File: logic/dmcr_sync.sv */
`timescale 1ns/1ps
module dmcr_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Raw pins and filtered levels
  input wire logic [dmcr_pkg::SYNC_W-1:0] raw,
  output logic [dmcr_pkg::SYNC_W-1:0] stable
);
  typedef struct packed {
    logic [dmcr_pkg::SYNC_W-1:0] s1;
    logic [dmcr_pkg::SYNC_W-1:0] s2;
    logic [dmcr_pkg::SYNC_W-1:0] s3;
    logic [dmcr_pkg::SYNC_W-1:0] out;
  } dmcr_sync_t;

  dmcr_sync_t s_reg;
  dmcr_sync_t s_next;

  // A lane changes only once the second and third stages agree
  always_comb begin
    s_next = s_reg;
    s_next.s1 = raw;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.out = (s_reg.s2 & ~(s_reg.s2 ^ s_reg.s3))
               | (s_reg.out & (s_reg.s2 ^ s_reg.s3));
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= {4{dmcr_pkg::SYNC_INIT}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign stable = s_reg.out;
endmodule
